/* File: acc_host.sv */
// Host model: serial bus master driving the converter port
`timescale 1ns/1ps
`default_nettype none
module acc_host (
  // Clock and pins
  input  wire logic clock,
  input  wire logic dout,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end
  // Shifts n bits MSB first; dout is sampled just before each rise
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    if (cs_n) begin
      @(negedge clock) cs_n <= 1'b0;
      repeat (4) @(negedge clock);
    end
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clock) sclk <= 1'b0;
      din <= tx[i];
      repeat (4) @(negedge clock);
      rx = {rx[62:0], dout};
      sclk <= 1'b1;
      repeat (3) @(negedge clock);
    end
    repeat (4) @(negedge clock);
    cs_n <= 1'b1;
    din  <= ~din;
    repeat (4) @(negedge clock);
  endtask : frame
  task automatic sel();
    @(negedge clock) cs_n <= 1'b0;
  endtask : sel
endmodule : acc_host
`default_nettype wire

/* File: acc_pkg.sv */
// Constants, types and checksum arithmetic of the converter serial port
package acc_pkg;
  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam logic [5:0]  A_STATUS     = 6'h00;
  localparam logic [5:0]  A_MODE       = 6'h01;
  localparam logic [5:0]  A_IFMODE     = 6'h02;
  localparam logic [5:0]  A_DATA       = 6'h04;
  localparam logic [5:0]  A_OFFSET     = 6'h30;
  localparam logic [5:0]  A_GAIN       = 6'h38;
  localparam logic [15:0] MODE_RST     = 16'h0000;
  localparam logic [15:0] IFMODE_RST   = 16'h0000;
  localparam logic [23:0] OFFSET_RST   = 24'h800000;
  localparam logic [23:0] GAIN_RST     = 24'h555555;
  localparam logic [23:0] MIDSCALE     = 24'h800000;
  // ---------------------------------------------------------------
  // Fields
  // ---------------------------------------------------------------
  localparam int          MODE_LSB     = 4;
  localparam int          BIPOLAR_BIT  = 15;
  localparam int          CK_LSB       = 2;
  localparam int          CONTREAD_BIT = 7;
  localparam logic [2:0]  MD_CONT      = 3'h0;
  localparam logic [2:0]  MD_STANDBY   = 3'h2;
  localparam logic [2:0]  MD_CAL_INT   = 3'h4;
  localparam logic [2:0]  MD_CAL_SYSZ  = 3'h6;
  localparam logic [2:0]  MD_CAL_SYSF  = 3'h7;
  localparam logic [1:0]  CK_OFF       = 2'h0;
  localparam logic [1:0]  CK_XOR       = 2'h1;
  localparam logic [7:0]  CMD_RD_DATA  = 8'h44;
  localparam logic [7:0]  CRC_POLY     = 8'h07;
  localparam logic [6:0]  RESET_ONES   = 7'h40;
  localparam int          GAIN_SHIFT   = 22;
  localparam logic [47:0] FS_NUM       = 48'h200000000000;

  typedef enum logic [1:0] {PH_CMD = 2'b00, PH_DATA = 2'b01, PH_CRC = 2'b11,
                            PH_DONE = 2'b10} acc_phase_t;
  typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_PRE = 2'b01,
                            CV_CAL = 2'b11} acc_conv_t;
  typedef struct packed {logic cs_n; logic sclk; logic din;} acc_pins_t;

  function automatic logic [7:0] crc_bit(logic [7:0] c, logic b);
    return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction : crc_bit

  function automatic logic [7:0] xor_bit(logic [7:0] x, logic b);
    return {x[6:0], x[7] ^ b};
  endfunction : xor_bit

  function automatic logic [7:0] crc_byte(logic [7:0] c, logic [7:0] v);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) r = crc_bit(r, v[i]);
    return r;
  endfunction : crc_byte

  function automatic logic [5:0] reg_bits(logic [5:0] a);
    if (a == A_STATUS) return 6'd8;
    if (a == A_MODE || a == A_IFMODE) return 6'd16;
    return 6'd24;
  endfunction : reg_bits

  function automatic logic signed [26:0] corr(logic [23:0] raw, logic [23:0] off);
    return $signed({3'b000, raw}) - $signed({3'b000, off}) + $signed({3'b000, MIDSCALE});
  endfunction : corr

  function automatic logic [23:0] scale(logic [23:0] raw, logic [23:0] off,
                                        logic [23:0] gain, logic bip);
    logic signed [51:0] p;
    p = 52'(corr(raw, off)) * 52'($signed({1'b0, gain}));
    p = p >>> GAIN_SHIFT;
    if (bip) p = p + $signed({28'h0, MIDSCALE});
    else p = p <<< 1;
    if (p < 0) return 24'h000000;
    if (p > 52'sh0ffffff) return 24'hffffff;
    return p[23:0];
  endfunction : scale

  function automatic logic [23:0] fs_gain(logic [23:0] raw, logic [23:0] off);
    logic signed [26:0] c;
    logic [47:0] q;
    c = corr(raw, off);
    if (c <= 0) return GAIN_RST;
    q = FS_NUM / {22'h0, c[25:0]};
    return (q > 48'h0000_00ff_ffff) ? 24'hffffff : q[23:0];
  endfunction : fs_gain
endpackage : acc_pkg

/* File: acc_port.sv */
// Converter serial port with calibration, result scaling and checksums
`timescale 1ns/1ps
`default_nettype none

module acc_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } acc_fifo_state_t;
  acc_fifo_state_t q, n;

  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2");
  end

  assign in_ready  = q.cnt != (AW + 1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data  = q.mem[q.rp];

  always_comb begin
    n = q;
    if (in_valid && in_ready) begin
      n.mem[q.wp] = in_data;
      n.wp = q.wp + 1'b1;
    end
    if (out_valid && out_ready) n.rp = q.rp + 1'b1;
    n.cnt = q.cnt + (AW + 1)'(in_valid && in_ready) - (AW + 1)'(out_valid && out_ready);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else if (clk_en) q <= n;
  end
endmodule : acc_fifo

module acc_port
  import acc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  // Raw results from the filter
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_code,
  output logic             raw_ready,
  // Filter settling period in clock cycles
  input  wire logic [31:0] settle_cycles,
  // Front end control
  output logic             cal_short_inputs,
  output logic             cal_busy
);
  typedef struct packed {
    acc_pins_t  s1, s2, s3;
    acc_phase_t ph;
    acc_conv_t  cv;
    logic [5:0] bitcnt, width;
    logic [6:0] ones;
    logic [7:0] cmd, din_byte, crc, xr;
    logic [31:0] sh, settle;
    logic [15:0] mode, ifmode;
    logic [23:0] data, offset, gain, pend;
    logic rdy_n, crc_fault, dout;
  } acc_state_t;
  acc_state_t q, n;

  logic        f_valid, f_ready, take, rise, fall, int_cal, contread;
  logic        cal_start, cal_done, rd_data_done, crc_bad, soft_rst;
  logic [23:0] f_data, scaled;
  logic [1:0]  ck;

  acc_fifo #(.W(24), .D(FIFO_DEPTH)) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .in_valid (raw_valid),
    .in_data  (raw_code),
    .in_ready (raw_ready),
    .out_valid(f_valid),
    .out_data (f_data),
    .out_ready(f_ready)
  );

  assign rise     = q.s2.sclk & ~q.s3.sclk;
  assign fall     = ~q.s2.sclk & q.s3.sclk;
  assign ck       = q.ifmode[CK_LSB+1:CK_LSB];
  assign contread = q.ifmode[CONTREAD_BIT];
  assign int_cal  = q.cv == CV_CAL && q.mode[6:4] == MD_CAL_INT;
  assign f_ready  = q.cv == CV_CAL || (q.cv == CV_IDLE && q.mode[6:4] == MD_CONT);
  assign take     = f_valid & f_ready;
  assign scaled   = scale(q.pend, q.offset, q.gain, q.mode[BIPOLAR_BIT]);
  assign dout     = q.dout;
  assign dout_oe  = ~q.s2.cs_n;
  assign cal_busy = q.cv == CV_CAL;
  assign cal_short_inputs = int_cal;

  // ---------------------------------------------------------------
  // Serial transactions and conversion path
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0]  c;
    logic [7:0]  nc;
    logic [7:0]  nx;
    logic [31:0] rv;
    logic        commit;
    c = {q.cmd[6:0], q.s2.din};
    nc = crc_bit(q.crc, q.sh[31]);
    nx = xor_bit(q.xr, q.sh[31]);
    rv = 32'h0;
    commit = 1'b0;
    n = q;
    cal_start = 1'b0;
    cal_done = 1'b0;
    rd_data_done = 1'b0;
    crc_bad = 1'b0;
    soft_rst = 1'b0;
    n.s1 = '{cs_n: cs_n, sclk: sclk, din: din};
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (q.s2.cs_n) begin
      n.ph = PH_CMD;
      n.bitcnt = 6'd0;
      n.crc = 8'h00;
      n.xr = 8'h00;
      n.ones = 7'd0;
    // Ready stays on the pin until the first clock fall shifts out the MSB
    end else if (contread && q.ph == PH_CMD && q.bitcnt == 6'd0 && !q.rdy_n && fall) begin
      n.ph = PH_DATA;
      n.cmd = CMD_RD_DATA;
      n.width = 6'd24;
      n.sh = {q.data, 8'h00};
      n.crc = crc_byte(8'h00, CMD_RD_DATA);
      n.xr = CMD_RD_DATA;
    end else if (rise) begin
      n.ones = q.s2.din ? q.ones + 7'd1 : 7'd0;
      if (q.s2.din && q.ones == RESET_ONES - 7'd1) soft_rst = 1'b1;
      n.bitcnt = q.bitcnt + 6'd1;
      case (q.ph)
        PH_CMD: begin
          n.cmd = c;
          n.crc = crc_bit(q.crc, q.s2.din);
          n.xr = xor_bit(q.xr, q.s2.din);
          if (q.bitcnt == 6'd7) begin
            n.bitcnt = 6'd0;
            n.ph = PH_DATA;
            n.width = reg_bits(c[5:0]);
            case (c[5:0])
              A_STATUS: rv = {q.rdy_n, q.crc_fault, 30'h0};
              A_MODE:   rv = {q.mode, 16'h0};
              A_IFMODE: rv = {q.ifmode, 16'h0};
              A_DATA:   rv = {q.data, 8'h0};
              A_OFFSET: rv = {q.offset, 8'h0};
              A_GAIN:   rv = {q.gain, 8'h0};
              default:  rv = 32'h0;
            endcase
            if (c[6]) n.sh = rv;
          end
        end
        PH_DATA: begin
          n.din_byte = {q.din_byte[6:0], q.s2.din};
          if (q.cmd[6]) begin
            n.crc = nc;
            n.xr = nx;
            n.sh = {q.sh[30:0], 1'b0};
            if (q.bitcnt == 6'd7 && contread && n.din_byte == CMD_RD_DATA)
              n.ifmode[CONTREAD_BIT] = 1'b0;
          end else begin
            n.crc = crc_bit(q.crc, q.s2.din);
            n.sh = {q.sh[30:0], q.s2.din};
          end
          if (q.bitcnt == q.width - 6'd1) begin
            n.bitcnt = 6'd0;
            n.ph = (ck != CK_OFF) ? PH_CRC : PH_DONE;
            if (q.cmd[6]) begin
              if (q.cmd[5:0] == A_DATA) rd_data_done = 1'b1;
              if (q.cmd[5:0] == A_STATUS) n.crc_fault = 1'b0;
              n.sh = {(ck == CK_XOR) ? nx : nc, 24'h0};
            end else if (ck == CK_OFF) begin
              commit = 1'b1;
            end
          end
        end
        PH_CRC: begin
          n.din_byte = {q.din_byte[6:0], q.s2.din};
          // A write keeps its data word in place for the commit
          if (q.cmd[6]) n.sh = {q.sh[30:0], 1'b0};
          if (q.bitcnt == 6'd7) begin
            n.ph = PH_DONE;
            if (!q.cmd[6] && n.din_byte != q.crc) crc_bad = 1'b1;
            else if (!q.cmd[6]) commit = 1'b1;
          end
        end
        default: n.bitcnt = q.bitcnt;
      endcase
    end
    if (crc_bad) n.crc_fault = 1'b1;
    if (rd_data_done) n.rdy_n = 1'b1;
    if (commit) begin
      case (q.cmd[5:0])
        A_MODE: begin
          n.mode = n.sh[15:0];
          cal_start = n.sh[6:4] == MD_CAL_INT || n.sh[6:4] == MD_CAL_SYSZ
                   || n.sh[6:4] == MD_CAL_SYSF;
        end
        A_IFMODE: n.ifmode = n.sh[15:0];
        A_OFFSET: if (!int_cal) n.offset = n.sh[23:0];
        A_GAIN:   if (!int_cal) n.gain = n.sh[23:0];
        default:  n.mode = q.mode;
      endcase
    end
    case (q.cv)
      CV_IDLE: if (take) begin
        n.pend = f_data;
        n.rdy_n = 1'b1;
        n.cv = CV_PRE;
      end
      CV_PRE: begin
        n.data = scaled;
        n.rdy_n = 1'b0;
        n.cv = CV_IDLE;
      end
      CV_CAL: if (q.settle < settle_cycles) begin
        n.settle = q.settle + 32'd1;
      end else if (take) begin
        cal_done = 1'b1;
        if (q.mode[6:4] == MD_CAL_SYSF) n.gain = fs_gain(f_data, q.offset);
        else n.offset = f_data + MIDSCALE;
        n.mode[6:4] = MD_STANDBY;
        n.rdy_n = 1'b0;
        n.cv = CV_IDLE;
      end
      default: n.cv = CV_IDLE;
    endcase
    if (cal_start) begin
      n.cv = CV_CAL;
      n.settle = 32'd0;
      n.rdy_n = 1'b1;
    end
    if (soft_rst) begin
      n.mode = MODE_RST;
      n.ifmode = IFMODE_RST;
      n.offset = OFFSET_RST;
      n.gain = GAIN_RST;
      n.data = 24'h000000;
      n.rdy_n = 1'b1;
      n.crc_fault = 1'b0;
      n.cv = CV_IDLE;
      n.ph = PH_CMD;
      n.bitcnt = 6'd0;
    end
    n.dout = (n.ph inside {PH_DATA, PH_CRC} && n.cmd[6]) ? n.sh[31] : n.rdy_n;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.s1 <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
      q.s2 <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
      q.s3 <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
      q.offset <= OFFSET_RST;
      q.gain <= GAIN_RST;
      q.mode <= MODE_RST;
      q.ifmode <= IFMODE_RST;
      q.rdy_n <= 1'b1;
      q.dout <= 1'b1;
    end else if (clk_en) begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock iff clk_en); endclocking
  default disable iff (!rst_n);

  sequence s_update;
    q.cv == CV_PRE && q.rdy_n ##1 !q.rdy_n && q.cv == CV_IDLE;
  endsequence

  a_cal_start_rdy: assert property (cal_start && !soft_rst |=> q.rdy_n && q.cv == CV_CAL)
    else $error("calibration start did not raise not-ready");
  a_cal_end_stby: assert property (cal_done && !soft_rst |=> !q.rdy_n && q.mode[6:4] == MD_STANDBY)
    else $error("calibration end did not enter standby");
  a_pre_update: assert property (q.cv == CV_IDLE && take && !cal_start && !soft_rst |=> s_update)
    else $error("ready not high one cycle before update");
  a_data_scaled: assert property (q.cv == CV_PRE && !soft_rst |=> q.data == $past(scaled))
    else $error("data register not scaled result");
  a_soft_reset: assert property (soft_rst |=> q.offset == OFFSET_RST && q.gain == GAIN_RST)
    else $error("interface reset missed coefficients");
  a_settle_wait: assert property (cal_done |-> q.settle >= settle_cycles)
    else $error("calibration ended before settling");
  a_coef_locked: assert property (int_cal && !cal_done && !soft_rst |=> $stable(q.offset))
    else $error("offset changed during internal calibration");
  a_read_ready: assert property (rd_data_done && !soft_rst && q.cv != CV_PRE |=> q.rdy_n)
    else $error("ready not high after data read");
  a_crc_fault: assert property (crc_bad |=> q.crc_fault)
    else $error("checksum fault not flagged");
  a_short_cal: assert property (q.cv == CV_CAL && q.mode[6:4] == MD_CAL_INT |-> cal_short_inputs)
    else $error("inputs not shorted in internal calibration");
endmodule : acc_port

`default_nettype wire

/* File: acc_port_test.sv */
// Testbench of the converter serial port
`timescale 1ns/1ps
`default_nettype none
module acc_port_test;
  import acc_pkg::*;
  logic        clock, rst_n, raw_valid, cs_n, sclk, din, dout, dout_oe;
  logic        raw_ready, cal_short_inputs, cal_busy;
  logic [23:0] raw_code, raw, off, gain, e24;
  logic [31:0] v;
  logic [63:0] rx;
  logic [2:0]  md;
  int          err_total, n_checks, n;

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  acc_port #(.FIFO_DEPTH(8)) u_acc_port (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .raw_valid(raw_valid), .raw_code(raw_code), .raw_ready(raw_ready),
    .settle_cycles(32'h190), .cal_short_inputs(cal_short_inputs), .cal_busy(cal_busy));
  acc_host u_host (.clock(clock), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [23:0] exp_scale(logic [23:0] r, o, g, logic b);
    longint p;
    p = ((longint'(r) - longint'(o) + 64'sh800000) * longint'(g)) >>> 22;
    p = b ? p + 64'sh800000 : p * 2;
    return (p < 0) ? 24'h000000 : (p > 64'shffffff) ? 24'hffffff : p[23:0];
  endfunction : exp_scale
  function automatic logic [23:0] exp_gain(logic [23:0] r, o);
    longint c;
    c = longint'(r) - longint'(o) + 64'sh800000;
    if (c <= 0) return GAIN_RST;
    c = (64'sh1 << 45) / c;
    return (c > 64'shffffff) ? 24'hffffff : c[23:0];
  endfunction : exp_gain
  function automatic logic [7:0] cks(logic [63:0] m, int n, bit x);
    logic [7:0] r;
    r = 8'h00;
    for (int i = n - 1; i >= 0; i--)
      if (x) r[i % 8] ^= m[i];
      else r = {r[6:0], 1'b0} ^ ((r[7] ^ m[i]) ? 8'h07 : 8'h00);
    return r;
  endfunction : cks

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [5:0] a, logic [31:0] d, int nb, bit ck, bit bad = 1'b0);
    logic [63:0] m, q;
    m = (64'(a) << nb) | 64'(d);
    if (ck) m = (m << 8) | 64'(cks(m, nb + 8, 1'b0) ^ {7'h0, bad});
    u_host.frame(m, nb + 8 + (ck ? 8 : 0), q);
  endtask : wr
  task automatic rd(logic [5:0] a, int nb, int ck, output logic [31:0] d);
    logic [63:0] m, q;
    int e;
    e = (ck != 0) ? 8 : 0;
    m = 64'({2'b01, a}) << nb;
    u_host.frame(m << e, 8 + nb + e, q);
    d = 32'((q >> e) & ((64'h1 << nb) - 64'h1));
    if (ck != 0) chk(q[7:0], cks(m | 64'(d), nb + 8, ck == 1));
  endtask : rd
  task automatic push(logic [23:0] r);
    @(negedge clock) raw_valid <= 1'b1;
    raw_code <= r;
    do @(posedge clock); while (raw_ready !== 1'b1);
    @(negedge clock) raw_valid <= 1'b0;
    raw_code <= ~r;
  endtask : push
  task automatic wait_rdy();
    u_host.sel();
    repeat (4) @(negedge clock);
    chk(dout_oe, 1);
    for (int i = 0; i < 400 && dout !== 1'b0; i++) @(negedge clock);
    chk(dout, 0);
  endtask : wait_rdy
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (80000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    raw_valid = 1'b0;
    raw_code = 24'h000000;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'hc6d587a3));
    repeat (12) @(posedge clock);
    @(negedge clock) rst_n <= 1'b1;
    repeat (4) @(negedge clock);
    rd(A_OFFSET, 24, 0, v);
    chk(v, OFFSET_RST);
    rd(A_GAIN, 24, 0, v);
    chk(v, GAIN_RST);
    for (int k = 0; k < 4; k++) begin
      off = 24'h7f0000 + 24'($urandom_range(0, 32'h1ffff));
      gain = 24'h400000 + 24'($urandom_range(0, 32'h1fffff));
      raw = (k == 3) ? 24'hffffff : (k == 2) ? 24'h000000 : 24'($urandom);
      wr(A_MODE, {k[0], 15'h0}, 16, 0);
      wr(A_OFFSET, off, 24, 0);
      wr(A_GAIN, gain, 24, 0);
      rd(A_GAIN, 24, 0, v);
      chk(v, gain);
      push(raw);
      wait_rdy();
      rd(A_DATA, 24, 0, v);
      chk(v, exp_scale(raw, off, gain, k[0]));
      rd(A_STATUS, 8, 0, v);
      chk(v[7], 1);
    end
    wr(A_MODE, 32'h0020, 16, 0);
    n = 0;
    for (int k = 0; k < 12; k++) begin
      @(negedge clock);
      if (raw_ready === 1'b1) n++;
      raw_valid <= 1'b1;
      raw_code <= 24'($urandom);
    end
    @(negedge clock) raw_valid <= 1'b0;
    chk(n, 8);
    wr(A_MODE, 32'h0000, 16, 0);
    chk(raw_ready, 1);
    // One raw stream stands for the single enabled channel
    for (int k = 0; k < 3; k++) begin
      md = (k == 0) ? MD_CAL_INT : (k == 1) ? MD_CAL_SYSZ : MD_CAL_SYSF;
      raw = 24'h7e0000 + 24'($urandom_range(0, 32'h3ffff));
      wr(A_MODE, 32'({md, 4'h0}), 16, 0);
      push(~raw);
      chk(cal_busy, 1);
      chk(cal_short_inputs, k == 0);
      rd(A_STATUS, 8, 0, v);
      chk(v[7], 1);
      if (k == 0) wr(A_OFFSET, 32'h123456, 24, 0);
      repeat (400) @(negedge clock);
      chk(cal_busy, 1);
      push(raw);
      for (int i = 0; i < 50 && cal_busy !== 1'b0; i++) @(negedge clock);
      chk(cal_busy, 0);
      rd(A_STATUS, 8, 0, v);
      chk(v[7], 0);
      rd(A_MODE, 16, 0, v);
      chk(v[6:4], MD_STANDBY);
      if (k < 2) off = raw + 24'h800000;
      else gain = exp_gain(raw, off);
      rd((k < 2) ? A_OFFSET : A_GAIN, 24, 0, v);
      chk(v, (k < 2) ? off : gain);
    end
    wr(A_IFMODE, 32'h0008, 16, 0);
    rd(A_OFFSET, 24, 2, v);
    chk(v, off);
    gain = 24'($urandom);
    wr(A_GAIN, gain, 24, 1);
    wr(A_OFFSET, 32'h0, 24, 1, 1);
    rd(A_STATUS, 8, 2, v);
    chk(v[6], 1);
    wr(A_IFMODE, 32'h0004, 16, 1);
    rd(A_GAIN, 24, 1, v);
    chk(v, gain);
    rd(A_OFFSET, 24, 1, v);
    chk(v, off);
    wr(A_MODE, 32'h0000, 16, 1);
    wr(A_IFMODE, 32'h0088, 16, 1);
    raw = 24'($urandom);
    e24 = exp_scale(raw, off, gain, 1'b0);
    push(raw);
    wait_rdy();
    u_host.frame(64'h0, 32, rx);
    chk(rx[31:8], e24);
    chk(rx[7:0], cks({32'h0, 8'h44, e24}, 32, 1'b0));
    // Leave continuous read by clocking the data-read command in during a read
    raw = 24'($urandom);
    e24 = exp_scale(raw, off, gain, 1'b0);
    push(raw);
    wait_rdy();
    u_host.frame(64'(32'h44000000), 32, rx);
    chk(rx[31:8], e24);
    rd(A_IFMODE, 16, 2, v);
    chk(v[7], 0);
    u_host.frame(64'hffffffffffffffff, 64, rx);
    repeat (25000) @(negedge clock);
    rd(A_OFFSET, 24, 0, v);
    chk(v, OFFSET_RST);
    rd(A_IFMODE, 16, 0, v);
    chk(v, IFMODE_RST);
    tally_and_finish();
  end
endmodule : acc_port_test
`default_nettype wire
